// File: overtemp_source.sv
// Model of the external overtemperature source.
`timescale 1ns/1ps
module overtemp_source (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	// Command
	input  wire logic        start_i,
	input  wire logic [11:0] len_i,
	// Line, open drain with pull-up
	output logic             line_n_o
);
	logic [11:0] left;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			left <= 12'h000;
		end else if (start_i) begin
			left <= len_i;
		end else if (left != 12'h000) begin
			left <= left - 12'h001;
		end
	end

	// A released line rises to the pull-up, never the last value.
	assign line_n_o = (left == 12'h000);
endmodule

// File: overtemp_step_tick.sv
// Step tick generator for the overtemperature duration count.
`timescale 1ns/1ps
module overtemp_step_tick #(
	parameter int unsigned STEP_CYCLES = 2845000
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	// Control
	input  wire logic run_i,
	input  wire logic restart_i,
	// Step
	output logic      tick_o
);
	localparam int CNT_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(STEP_CYCLES - 1);

	logic [CNT_W-1:0] cycle_cnt;
	logic [CNT_W-1:0] next_cycle_cnt;

	// Restarting on each assertion keeps steps aligned to its leading edge.
	always_comb begin
		next_cycle_cnt = cycle_cnt;
		if (restart_i || !run_i || cycle_cnt == LAST) begin
			next_cycle_cnt = '0;
		end else begin
			next_cycle_cnt = cycle_cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cycle_cnt <= '0;
		end else begin
			cycle_cnt <= next_cycle_cnt;
		end
	end

	assign tick_o = run_i && !restart_i && cycle_cnt == LAST;
endmodule

// File: overtemp_timer_fan_config.sv
// Overtemperature timer, fan pulse selection and pin configuration block.
`timescale 1ns/1ps
module overtemp_timer_fan_config
	import overtemp_timer_pkg::*;
#(
	parameter int unsigned STEP_CYCLES_P = STEP_CYCLES
) (
	// Clock and reset
	input  wire logic                                  ref_clk_i,
	input  wire logic                                  sys_rst_i,
	// Avalon-MM slave
	input  wire logic [overtemp_timer_pkg::ADDR_W-1:0] address_i,
	input  wire logic                                  read_i,
	input  wire logic                                  write_i,
	input  wire logic [overtemp_timer_pkg::DATA_W-1:0] writedata_i,
	input  wire logic [overtemp_timer_pkg::BE_W-1:0]   byteenable_i,
	output logic      [overtemp_timer_pkg::DATA_W-1:0] readdata_o,
	output logic                                       waitrequest_o,
	// Overtemperature pin, active low
	input  wire logic                                  overtemp_line_n_i,
	// Fan pulse selections
	output logic      [overtemp_timer_pkg::SEL_W-1:0]  fan_one_pulse_sel_o,
	output logic      [overtemp_timer_pkg::SEL_W-1:0]  fan_two_pulse_sel_o,
	output logic      [overtemp_timer_pkg::SEL_W-1:0]  fan_three_pulse_sel_o,
	output logic      [overtemp_timer_pkg::SEL_W-1:0]  fan_four_pulse_sel_o,
	// Pin functions
	output logic                                       alert_pin_select_o,
	output logic                                       overtemp_pin_select_o,
	output logic      [overtemp_timer_pkg::THR_W-1:0]  twowire_threshold_sel_o,
	// Interrupts
	output logic                                       irq_o,
	output logic                                       alert_o
);
	import overtemp_timer_pkg::*;

	// Bus state.
	logic              ack;
	logic              next_ack;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] next_rdata;
	logic [IDX_W-1:0]  index;
	logic              take_wr;
	logic              take_rd;
	logic [REG_W-1:0]  wbyte;
	logic [REG_W-1:0]  read_mux;

	// Software registers.
	logic [REG_W-1:0]     duration_limit;
	logic [REG_W-1:0]     next_duration_limit;
	logic [REG_W-1:0]     pulse_sel;
	logic [REG_W-1:0]     next_pulse_sel;
	logic [PIN_CFG_W-1:0] pin_cfg;
	logic [PIN_CFG_W-1:0] next_pin_cfg;
	logic [REG_W-1:0]     config3;
	logic [REG_W-1:0]     next_config3;
	logic                 lock;
	logic                 next_lock;
	logic [REG_W-1:0]     int_mask;
	logic [REG_W-1:0]     next_int_mask;
	logic [REG_W-1:0]     int_status;
	logic [REG_W-1:0]     next_int_status;

	// Overtemperature timing state.
	logic             line_meta;
	logic             line_sync;
	logic             active;
	logic             active_prev;
	logic             next_active_prev;
	logic             assert_edge;
	logic             monitor_en;
	logic             step_tick;
	logic             assert_flag_lsb;
	logic             next_assert_flag_lsb;
	logic [REG_W-1:0] duration_count;
	logic [REG_W-1:0] next_duration_count;
	logic             fired;
	logic             next_fired;
	logic             fan_four_pulse_sel_or_timer_event;
	logic             timer_read;
	logic [REG_W-1:0] timer_view;

	assign index   = address_i[IDX_LO +: IDX_W];
	assign take_wr = write_i && ack && byteenable_i[0];
	assign take_rd = read_i && ack;
	assign wbyte   = writedata_i[REG_W-1:0];

	// The first stage feeds only the second; the pin is asynchronous.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			line_meta <= 1'b0;
			line_sync <= 1'b0;
		end else begin
			line_meta <= !overtemp_line_n_i;
			line_sync <= line_meta;
		end
	end

	assign monitor_en  = config3[BIT_MON_EN] && pin_cfg[BIT_OVT_SEL];
	assign active      = line_sync && monitor_en;
	assign assert_edge = active && !active_prev;
	assign timer_read  = take_rd && index == IDX_TIMER;

	overtemp_step_tick #(
		.STEP_CYCLES (STEP_CYCLES_P)
	) u_step (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (active),
		.restart_i (assert_edge || timer_read),
		.tick_o    (step_tick)
	);

	// Duration count, assertion flag and limit comparison.
	always_comb begin
		next_active_prev     = active;
		next_assert_flag_lsb = assert_flag_lsb;
		next_duration_count  = duration_count;
		next_fired           = fired;
		fan_four_pulse_sel_or_timer_event  = 1'b0;
		// set on assertion wins over read clear.
		if (assert_edge) begin
			next_assert_flag_lsb = 1'b1;
		end else if (timer_read) begin
			next_assert_flag_lsb = 1'b0;
		end
		if (assert_edge || timer_read) begin
			next_duration_count = RST_ZERO;
		end else if (step_tick && duration_count != COUNT_MAX) begin
			next_duration_count = duration_count + 8'h01;
		end
		if (assert_edge && duration_limit == RST_ZERO) begin
			fan_four_pulse_sel_or_timer_event = 1'b1;
		end
		if (active && !fired && duration_limit != RST_ZERO
		    && duration_count > duration_limit) begin
			fan_four_pulse_sel_or_timer_event = 1'b1;
		end
		if (assert_edge) begin
			next_fired = 1'b0;
		end else if (fan_four_pulse_sel_or_timer_event) begin
			next_fired = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			active_prev     <= 1'b0;
			assert_flag_lsb <= 1'b0;
			duration_count  <= RST_ZERO;
			fired           <= 1'b0;
		end else begin
			active_prev     <= next_active_prev;
			assert_flag_lsb <= next_assert_flag_lsb;
			duration_count  <= next_duration_count;
			fired           <= next_fired;
		end
	end

	// upper bits hidden until two steps.
	always_comb begin
		if (duration_count >= VISIBLE_STEPS) begin
			timer_view = duration_count;
		end else begin
			timer_view = {7'h00, assert_flag_lsb};
		end
	end

	// Software registers with lock and write-one-to-clear status.
	always_comb begin
		next_duration_limit = duration_limit;
		next_pulse_sel      = pulse_sel;
		next_pin_cfg        = pin_cfg;
		next_config3        = config3;
		next_lock           = lock;
		next_int_mask       = int_mask;
		next_int_status     = int_status;
		if (take_wr) begin
			unique case (index)
				IDX_LIMIT: begin
					next_duration_limit = wbyte;
				end
				IDX_PULSES: begin
					next_pulse_sel = wbyte;
				end
				IDX_PIN_CFG: begin
					if (!lock) begin
						next_pin_cfg = wbyte[PIN_CFG_W-1:0];
					end
				end
				IDX_CONFIG3: begin
					if (!lock) begin
						next_config3 = wbyte;
					end
				end
				IDX_CONFIG1: begin
					next_lock = lock || wbyte[BIT_LOCK];
				end
				IDX_INT_MASK2: begin
					next_int_mask = wbyte;
				end
				IDX_INT_STATUS2: begin
					next_int_status = int_status & ~wbyte;
				end
				// Test registers and holes take no write.
				default: begin
				end
			endcase
		end
		// An event in the clearing cycle still sets its bit.
		if (fan_four_pulse_sel_or_timer_event) begin
			next_int_status[BIT_TIMER_EVT] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			duration_limit <= RST_ZERO;
			pulse_sel      <= RST_PULSES;
			pin_cfg        <= RST_ZERO[PIN_CFG_W-1:0];
			config3        <= RST_ZERO;
			lock           <= 1'b0;
			int_mask       <= RST_ZERO;
			int_status     <= RST_ZERO;
		end else begin
			duration_limit <= next_duration_limit;
			pulse_sel      <= next_pulse_sel;
			pin_cfg        <= next_pin_cfg;
			config3        <= next_config3;
			lock           <= next_lock;
			int_mask       <= next_int_mask;
			int_status     <= next_int_status;
		end
	end

	// Read multiplexer; unmapped and test registers read zero.
	always_comb begin
		unique case (index)
			IDX_TIMER:       read_mux = timer_view;
			IDX_LIMIT:       read_mux = duration_limit;
			IDX_PULSES:      read_mux = pulse_sel;
			IDX_PIN_CFG:     read_mux = {4'h0, pin_cfg};
			IDX_CONFIG3:     read_mux = config3;
			IDX_CONFIG1:     read_mux = {6'h00, lock, 1'b0};
			IDX_INT_MASK2:   read_mux = int_mask;
			IDX_INT_STATUS2: read_mux = int_status;
			IDX_TEST_ONE:    read_mux = RST_ZERO;
			IDX_TEST_TWO:    read_mux = RST_ZERO;
			default:         read_mux = RST_ZERO;
		endcase
	end

	// One wait cycle gives the read data a full cycle to settle.
	always_comb begin
		next_ack   = (read_i || write_i) && !ack;
		next_rdata = rdata;
		if (read_i && !ack) begin
			next_rdata = {24'h000000, read_mux};
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack   <= 1'b0;
			rdata <= '0;
		end else begin
			ack   <= next_ack;
			rdata <= next_rdata;
		end
	end

	assign waitrequest_o = (read_i || write_i) && !ack;
	assign readdata_o    = rdata;

	assign fan_one_pulse_sel_o   = pulse_sel[0*SEL_W +: SEL_W];
	assign fan_two_pulse_sel_o   = pulse_sel[1*SEL_W +: SEL_W];
	assign fan_three_pulse_sel_o = pulse_sel[2*SEL_W +: SEL_W];
	assign fan_four_pulse_sel_o  = pulse_sel[3*SEL_W +: SEL_W];

	assign alert_pin_select_o      = pin_cfg[BIT_ALERT_SEL];
	assign overtemp_pin_select_o   = pin_cfg[BIT_OVT_SEL];
	assign twowire_threshold_sel_o = pin_cfg[THR_LSB +: THR_W];

	assign irq_o   = |(int_status & ~int_mask);
	assign alert_o = irq_o && pin_cfg[BIT_ALERT_SEL];
endmodule

// File: overtemp_timer_fan_config_checker.sv
// Port-level assertions of the overtemperature timer block.
`timescale 1ns/1ps
module overtemp_timer_fan_config_checker
	import overtemp_timer_pkg::*;
(
	input wire logic        ref_clk_i,
	input wire logic        sys_rst_i,
	input wire logic [9:0]  address_i,
	input wire logic        read_i,
	input wire logic        write_i,
	input wire logic [31:0] readdata_o,
	input wire logic        waitrequest_o,
	input wire logic        overtemp_line_n_i,
	input wire logic [1:0]  fan_one_pulse_sel_o,
	input wire logic [1:0]  fan_two_pulse_sel_o,
	input wire logic [1:0]  fan_three_pulse_sel_o,
	input wire logic [1:0]  fan_four_pulse_sel_o,
	input wire logic        alert_pin_select_o,
	input wire logic        irq_o,
	input wire logic        alert_o
);
	logic       wr_done;
	logic [7:0] sels;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	assign wr_done = write_i && !waitrequest_o;
	assign sels = {fan_four_pulse_sel_o, fan_three_pulse_sel_o,
		fan_two_pulse_sel_o, fan_one_pulse_sel_o};

	sequence s_one_wait;
		waitrequest_o ##1 !waitrequest_o;
	endsequence

	sequence s_rd(logic [7:0] idx);
		read_i && !waitrequest_o && address_i[9:2] == idx;
	endsequence

	chk_wait_one: assert property ($rose(read_i || write_i) |-> s_one_wait)
		else $error("bus wait not one cycle");
	chk_alert_gate: assert property (alert_o == (irq_o && alert_pin_select_o))
		else $error("alert not irq gated by pin select");
	chk_pulse_reset: assert property ($fell(sys_rst_i) |-> sels == 8'h55)
		else $error("pulse selections not at reset value");
	chk_sel_hold: assert property (!$stable(sels) |-> $past(wr_done))
		else $error("pulse selections changed without write");
	chk_pulse_read: assert property (s_rd(IDX_PULSES) |-> readdata_o == sels)
		else $error("pulse register differs from ports");
	chk_irq_rise: assert property ($rose(irq_o) |->
		!$past(overtemp_line_n_i, 3) || $past(wr_done))
		else $error("irq rose without cause");
	chk_irq_sticky: assert property ($fell(irq_o) |-> $past(wr_done))
		else $error("irq fell without write");
	chk_test_zero: assert property ((s_rd(IDX_TEST_ONE) or
		s_rd(IDX_TEST_TWO)) |-> readdata_o == 32'h0)
		else $error("test register not zero");
endmodule

bind overtemp_timer_fan_config overtemp_timer_fan_config_checker chk_i (.*);

// File: overtemp_timer_pkg.sv
// Constants, register map and timing figures of the overtemperature timer.
// How it works
// - Upper timer bits zero until 45.52 ms.
// - Bit zero sets on assertion, read clears.
// - Past 45.52 ms, eight-bit count, 22.76 ms steps.
// - Eight-bit duration limit, software readable and writable.
// - Exceeding limit sets status two bit five.
// - Zero limit interrupts at once on assertion.
// - Two-bit pulse count per fan, reset 0x55.
// - Pin bit zero: alert output or 2.5 V.
// - Pin bit one: overtemp input or 5 V.
// - Pin bits 3:2 pick two-wire threshold.
// - Lock bit makes pin configuration read-only.
// - Enable bit turns on overtemperature monitoring while pin bit one selects the overtemp input.
// - Mask bit five suppresses timer alert.
package overtemp_timer_pkg;

	// Bus shape.
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;
	localparam int REG_W  = 8;
	localparam int IDX_W  = 8;
	localparam int IDX_LO = 2;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_INT_STATUS2 = 8'h42;
	localparam logic [IDX_W-1:0] IDX_CONFIG1     = 8'h60;
	localparam logic [IDX_W-1:0] IDX_INT_MASK2   = 8'h75;
	localparam logic [IDX_W-1:0] IDX_CONFIG3     = 8'h78;
	localparam logic [IDX_W-1:0] IDX_TIMER       = 8'h79;
	localparam logic [IDX_W-1:0] IDX_LIMIT       = 8'h7a;
	localparam logic [IDX_W-1:0] IDX_PULSES      = 8'h7b;
	localparam logic [IDX_W-1:0] IDX_PIN_CFG     = 8'h7d;
	localparam logic [IDX_W-1:0] IDX_TEST_ONE    = 8'h7e;
	localparam logic [IDX_W-1:0] IDX_TEST_TWO    = 8'h7f;

	// Reset values.
	localparam logic [REG_W-1:0] RST_ZERO   = 8'h00;
	localparam logic [REG_W-1:0] RST_PULSES = 8'h55;

	// Field positions.
	localparam int BIT_LOCK      = 1;
	localparam int BIT_MON_EN    = 1;
	localparam int BIT_TIMER_EVT = 5;
	localparam int BIT_ALERT_SEL = 0;
	localparam int BIT_OVT_SEL   = 1;
	localparam int THR_LSB       = 2;
	localparam int THR_W         = 2;
	localparam int PIN_CFG_W     = 4;
	localparam int SEL_W         = 2;
	localparam int FANS          = 4;

	// Timing: one timer step, and steps before the count becomes visible.
	localparam int CLK_PERIOD_NS = 8;
	localparam int STEP_NS       = 22_760_000;
	localparam int STEP_CYCLES   = STEP_NS / CLK_PERIOD_NS;
	localparam logic [REG_W-1:0] VISIBLE_STEPS = 8'h02;
	localparam logic [REG_W-1:0] COUNT_MAX     = 8'hff;

endpackage

// File: tb_top.sv
// Self-checking bench of the overtemperature timer block.
`timescale 1ns/1ps
module tb_top;
	import overtemp_timer_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [9:0]  address_i = 10'h000;
	logic        read_i = 1'b0;
	logic        write_i = 1'b0;
	logic [31:0] writedata_i = 32'h0;
	logic [3:0]  byteenable_i = 4'h1;
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic        overtemp_line_n_i;
	logic [1:0]  fan_one_pulse_sel_o;
	logic [1:0]  fan_two_pulse_sel_o;
	logic [1:0]  fan_three_pulse_sel_o;
	logic [1:0]  fan_four_pulse_sel_o;
	logic        alert_pin_select_o;
	logic        overtemp_pin_select_o;
	logic [1:0]  twowire_threshold_sel_o;
	logic        irq_o;
	logic        alert_o;
	logic        start = 1'b0;
	logic [11:0] len = 12'h000;
	logic [31:0] rd;
	int          mismatches = 0;
	int          total_checks = 0;
	int          cycles = 0;
	// Rows: index, reset value, write data, value read back.
	logic [31:0] rows [7] = '{32'h7a00a5a5, 32'h7b551b1b, 32'h7d00fe0e,
		32'h7e00ff00, 32'h7f00ff00, 32'h7900ff00, 32'h1000ff00};

	overtemp_timer_fan_config #(.STEP_CYCLES_P(4)) dut (.*);
	overtemp_source src (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.start_i(start), .len_i(len), .line_n_o(overtemp_line_n_i));

	initial begin
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// A hung handshake would otherwise stall the run forever.
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			$display("[ERR] %s exp %h got %h", nm, exp, got);
			mismatches++;
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd, output logic [31:0] q);
		address_i <= {idx, 2'h0};
		writedata_i <= {24'h0, wd};
		read_i <= !wr;
		write_i <= wr;
		// Waitrequest is read mid-cycle, so the launching edge cannot race it.
		@(negedge ref_clk_i);
		while (waitrequest_o !== 1'b0) begin
			@(negedge ref_clk_i);
		end
		q = readdata_o;
		@(posedge ref_clk_i);
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		bus(1'b1, idx, wd, rd);
	endtask

	task automatic rdchk(input string nm, input logic [7:0] idx,
		input logic [31:0] exp);
		bus(1'b0, idx, 8'h00, rd);
		chk(nm, exp, rd);
	endtask

	task automatic overtemp_line(input logic [11:0] n);
		start <= 1'b1;
		len <= n;
		@(posedge ref_clk_i);
		start <= 1'b0;
		repeat (n + 12'd6) @(posedge ref_clk_i);
	endtask

	initial begin
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		foreach (rows[i]) begin
			rdchk("reset", rows[i][31:24], {24'h0, rows[i][23:16]});
			wr(rows[i][31:24], rows[i][15:8]);
			rdchk("readback", rows[i][31:24], {24'h0, rows[i][7:0]});
		end
		chk("fan sels", 32'h1b, {24'h0, fan_four_pulse_sel_o,
			fan_three_pulse_sel_o, fan_two_pulse_sel_o, fan_one_pulse_sel_o});
		chk("pin sels", 32'he, {28'h0, twowire_threshold_sel_o,
			overtemp_pin_select_o, alert_pin_select_o});
		overtemp_line(12'd4);
		rdchk("timer off", IDX_TIMER, 32'h0);
		wr(IDX_CONFIG3, 8'h02);
		wr(IDX_PIN_CFG, 8'h03);
		wr(IDX_LIMIT, 8'h00);
		overtemp_line(12'd4);
		chk("zero limit irq", 32'h1, {31'h0, irq_o});
		chk("alert", 32'h1, {31'h0, alert_o});
		rdchk("flag", IDX_TIMER, 32'h1);
		rdchk("flag clear", IDX_TIMER, 32'h0);
		rdchk("status", IDX_INT_STATUS2, 32'h20);
		wr(IDX_INT_STATUS2, 8'h20);
		chk("irq clear", 32'h0, {31'h0, irq_o});
		wr(IDX_INT_MASK2, 8'h20);
		overtemp_line(12'd4);
		chk("masked", 32'h0, {31'h0, irq_o});
		wr(IDX_INT_MASK2, 8'h00);
		chk("unmasked", 32'h1, {31'h0, irq_o});
		wr(IDX_INT_STATUS2, 8'h20);
		wr(IDX_LIMIT, 8'h03);
		overtemp_line(12'd10);
		chk("under limit", 32'h0, {31'h0, irq_o});
		overtemp_line(12'd40);
		chk("over limit", 32'h1, {31'h0, irq_o});
		// Forty cycles at four per step give ten steps, one step slack.
		bus(1'b0, IDX_TIMER, 8'h00, rd);
		chk("count", 32'h1, {31'h0, rd >= 32'd9 && rd <= 32'd11});
		rdchk("restart", IDX_TIMER, 32'h0);
		overtemp_line(12'd1100);
		rdchk("saturate", IDX_TIMER, 32'hff);
		wr(IDX_CONFIG1, 8'h02);
		wr(IDX_PIN_CFG, 8'h00);
		rdchk("locked", IDX_PIN_CFG, 32'h3);
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		rdchk("unlocked", IDX_PIN_CFG, 32'h0);
		chk("sels reset", 32'h55, {24'h0, fan_four_pulse_sel_o,
			fan_three_pulse_sel_o, fan_two_pulse_sel_o, fan_one_pulse_sel_o});
		end_of_test();
	end
endmodule
